// >>> hdl/pwr_seq_pkg.sv
package pwr_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus geometry: byte address, one 32-bit word per register
  localparam int ADDR_W = 18;
  localparam int IDX_W = 16;

  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_WAKE_IRQ_CTL = 16'hFF94;
  localparam logic [15:0] IDX_MISC_CTL0 = 16'hFFF1;
  localparam logic [15:0] IDX_MCLK_CTL = 16'h008F;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFE0;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hFFE1;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] WIC_RST = 8'h00;
  localparam logic [7:0] MC0_RST = 8'h00;
  localparam logic [7:0] MCC_RST = 8'h0A;
  localparam logic [2:0] IRQ_RST = 3'h0;

  // writable bits
  localparam logic [7:0] WIC_WMASK = 8'hBF;
  localparam logic [7:0] MC0_WMASK = 8'h83;

  ////////////////////////////////////////////////////////////////////////////////
  // wake_irq_control fields
  localparam int WIC_ROUTE = 7;
  localparam int WIC_RTC_EN = 5;
  localparam int WIC_RTC_FLAG = 4;
  localparam int WIC_USB_EN = 3;
  localparam int WIC_USB_FLAG = 2;
  localparam int WIC_KP_EN = 1;
  localparam int WIC_KP_FLAG = 0;

  // misc_control_zero fields
  localparam int MC0_PDR = 7;

  // master_clock_control fields
  localparam int MCC_HSO_DIS = 7;
  localparam int MCC_KP_DIS = 6;
  localparam int MCC_SC_DIS = 5;
  localparam int MCC_USB_DIS = 4;
  localparam int MCC_OSC32K_DIS = 3;

  // irq status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_DOWN = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_READY = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing counts, in cpu clock cycles
  localparam int GRACE_CYCLES = 32;
  localparam int SETTLE_CYCLES = 512;
  localparam int CNT_W = 10;
  localparam int CPU_DIV_DEFAULT = 4;

  typedef enum logic [1:0] {ST_RUN, ST_GRACE, ST_DOWN, ST_SETTLE} seq_state_t;

endpackage

// >>> hdl/cpu_tick_gen.sv
`timescale 1ns/1ps

// one-cycle cpu clock enable; stops while run is low
module cpu_tick_gen #(
  parameter int DIV = pwr_seq_pkg::CPU_DIV_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic run,
  output logic cpu_tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tick_regs_t;

  tick_regs_t s_reg;
  tick_regs_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (run) begin
      if (s_reg.cnt == 8'(DIV - 1)) begin
        s_next.cnt = 8'h00;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cpu_tick = s_reg.tick;

endmodule

// >>> hdl/power_down_wake_sequencer.sv
`timescale 1ns/1ps

// Behaviour
// [R01] power down stops core, clocks, peripherals
// [R02] only 32 kHz oscillator runs when down
// [R03] clocks run 32 cpu cycles first
// [R04] firmware halts core within grace window
// [R05] then oscillator, pll, vref, bias off
// [R06] firmware sets route select before request
// [R07] firmware enters down only via request
// [R08] or ext 0, 4, 5 sources onto ext0
// [R09] route select redirects all sources to ext0
// [R10] wake restores power, restarts clocks
// [R11] ext0 released after 512 cpu cycles
// [R12] reading wake register clears route select
// [R13] per-block clock gating by control bits
// [R14] wake register resets to zero
// [R15] request overrides individual control bits
// [R16] rtc keeps running on 32 kHz oscillator
// [R17] keypad disable bit gates keypad clock
// [R18] settle counter restarts, holds when stopped
module power_down_wake_sequencer #(
  parameter int CPU_DIV = pwr_seq_pkg::CPU_DIV_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [17:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [7:0] user_io_pins,
  input wire logic sc_irq,
  input wire logic rtc_event,
  input wire logic usb_event,
  input wire logic keypad_event,
  output logic ext_irq_zero,
  output logic ext_irq_four,
  output logic ext_irq_five,
  output logic irq,
  output logic core_clock_en,
  output logic sc_clock_en,
  output logic usb_clock_en,
  output logic keypad_clock_en,
  output logic rtc_clock_en,
  output logic osc32k_en,
  output logic hs_osc_en,
  output logic pll_en,
  output logic vref_en,
  output logic bias_en
);

  typedef struct packed {
    pwr_seq_pkg::seq_state_t state;
    logic [9:0] cnt;
    logic [7:0] wic;
    logic [7:0] mc0;
    logic [7:0] mcc;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic wake_hold;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq;
    logic ext_irq_zero;
    logic ext_irq_four;
    logic ext_irq_five;
    logic core_clock_en;
    logic sc_clock_en;
    logic usb_clock_en;
    logic keypad_clock_en;
    logic rtc_clock_en;
    logic osc32k_en;
    logic hs_osc_en;
    logic pll_en;
    logic vref_en;
    logic bias_en;
  } seq_regs_t;

  seq_regs_t s_reg;
  seq_regs_t s_next;
  logic cpu_tick;
  logic req;
  logic accept;
  logic [15:0] idx;
  logic ext5_src;
  logic user_any;
  logic merged;
  logic wake;
  logic down;
  logic ovr;
  logic [2:0] evt;

  ////////////////////////////////////////////////////////////////////////////////
  // cpu clock enable, frozen while clocks are gated off
  cpu_tick_gen #(
    .DIV(CPU_DIV)
  ) u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(s_reg.state != pwr_seq_pkg::ST_DOWN),
    .cpu_tick(cpu_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    evt = 3'h0;
    req = read | write;
    accept = req & ~s_reg.waitrequest;
    idx = address[17:2];
    user_any = |user_io_pins;
    ext5_src = (s_reg.wic[pwr_seq_pkg::WIC_RTC_FLAG] & s_reg.wic[pwr_seq_pkg::WIC_RTC_EN])
      | (s_reg.wic[pwr_seq_pkg::WIC_USB_FLAG] & s_reg.wic[pwr_seq_pkg::WIC_USB_EN])
      | (s_reg.wic[pwr_seq_pkg::WIC_KP_FLAG] & s_reg.wic[pwr_seq_pkg::WIC_KP_EN]);
    merged = user_any | (s_reg.wic[pwr_seq_pkg::WIC_ROUTE] & (sc_irq | ext5_src)); // [R08] [R09]
    // without route select only the user pins can wake
    wake = s_reg.wic[pwr_seq_pkg::WIC_ROUTE] ? (user_any | sc_irq | ext5_src) : user_any; // [R08]

    // two-cycle answer: data built while waitrequest high, effects at release
    s_next.waitrequest = ~(req & s_reg.waitrequest);
    if (req & s_reg.waitrequest) begin
      s_next.readdata = 32'h0000_0000;
      case (idx)
        pwr_seq_pkg::IDX_WAKE_IRQ_CTL: s_next.readdata[7:0] = s_reg.wic;
        pwr_seq_pkg::IDX_MISC_CTL0: s_next.readdata[7:0] = s_reg.mc0;
        pwr_seq_pkg::IDX_MCLK_CTL: s_next.readdata[7:0] = s_reg.mcc;
        pwr_seq_pkg::IDX_IRQ_STATUS: s_next.readdata[2:0] = s_reg.irq_status;
        pwr_seq_pkg::IDX_IRQ_MASK: s_next.readdata[2:0] = s_reg.irq_mask;
        default: s_next.readdata = 32'h0000_0000;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register writes and read side effects
    if (accept & write & byteenable[0]) begin
      case (idx)
        pwr_seq_pkg::IDX_WAKE_IRQ_CTL: begin
          s_next.wic[7] = writedata[7];
          s_next.wic[pwr_seq_pkg::WIC_RTC_EN] = writedata[5];
          s_next.wic[pwr_seq_pkg::WIC_USB_EN] = writedata[3];
          s_next.wic[pwr_seq_pkg::WIC_KP_EN] = writedata[1];
          // flags are write-one-to-clear
          s_next.wic[4] = s_reg.wic[4] & ~writedata[4];
          s_next.wic[2] = s_reg.wic[2] & ~writedata[2];
          s_next.wic[0] = s_reg.wic[0] & ~writedata[0];
        end
        pwr_seq_pkg::IDX_MISC_CTL0: s_next.mc0 = writedata[7:0] & pwr_seq_pkg::MC0_WMASK;
        pwr_seq_pkg::IDX_MCLK_CTL: s_next.mcc = writedata[7:0]; // [R13]
        pwr_seq_pkg::IDX_IRQ_STATUS: s_next.irq_status = s_reg.irq_status & ~writedata[2:0];
        pwr_seq_pkg::IDX_IRQ_MASK: s_next.irq_mask = writedata[2:0];
        default: s_next.mc0 = s_next.mc0;
      endcase
    end
    if (accept & read & (idx == pwr_seq_pkg::IDX_WAKE_IRQ_CTL)) begin
      s_next.wic[pwr_seq_pkg::WIC_ROUTE] = 1'b0; // [R12]
    end
    // event set wins over a clear in the same cycle
    if (rtc_event) begin
      s_next.wic[pwr_seq_pkg::WIC_RTC_FLAG] = 1'b1;
    end
    if (usb_event) begin
      s_next.wic[pwr_seq_pkg::WIC_USB_FLAG] = 1'b1;
    end
    if (keypad_event) begin
      s_next.wic[pwr_seq_pkg::WIC_KP_FLAG] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // power-down sequencer
    case (s_reg.state)
      pwr_seq_pkg::ST_RUN: begin
        if (s_reg.mc0[pwr_seq_pkg::MC0_PDR]) begin
          s_next.state = pwr_seq_pkg::ST_GRACE; // [R01]
          s_next.cnt = 10'h000;
        end
      end
      pwr_seq_pkg::ST_GRACE: begin
        // core is expected to halt itself here; no handshake exists
        if (cpu_tick) begin
          if (s_reg.cnt == 10'(pwr_seq_pkg::GRACE_CYCLES - 1)) begin
            s_next.state = pwr_seq_pkg::ST_DOWN; // [R03] [R04]
            s_next.cnt = 10'h000;
            evt[pwr_seq_pkg::IRQ_DOWN] = 1'b1;
          end else begin
            s_next.cnt = s_reg.cnt + 10'h001;
          end
        end
      end
      pwr_seq_pkg::ST_DOWN: begin
        if (wake) begin
          s_next.state = pwr_seq_pkg::ST_SETTLE; // [R10]
          s_next.cnt = 10'h000; // [R18]
          evt[pwr_seq_pkg::IRQ_WAKE] = 1'b1;
        end
      end
      pwr_seq_pkg::ST_SETTLE: begin
        // counts only on cpu ticks, so it holds whenever they stop
        if (cpu_tick) begin
          if (s_reg.cnt == 10'(pwr_seq_pkg::SETTLE_CYCLES - 1)) begin
            s_next.state = pwr_seq_pkg::ST_RUN; // [R11]
            s_next.cnt = 10'h000;
            s_next.mc0[pwr_seq_pkg::MC0_PDR] = 1'b0;
            s_next.wake_hold = 1'b1;
            evt[pwr_seq_pkg::IRQ_READY] = 1'b1;
          end else begin
            s_next.cnt = s_reg.cnt + 10'h001; // [R18]
          end
        end
      end
      default: s_next.state = pwr_seq_pkg::ST_RUN;
    endcase
    if ((s_reg.state == pwr_seq_pkg::ST_RUN) & ~merged) begin
      s_next.wake_hold = 1'b0;
    end
    s_next.irq_status = s_next.irq_status | evt;
    s_next.irq = |(s_next.irq_status & s_next.irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt routing; nothing reaches ext0 until the settle count ends
    if (s_next.state == pwr_seq_pkg::ST_RUN) begin
      s_next.ext_irq_zero = user_any | s_next.wake_hold
        | (s_reg.wic[pwr_seq_pkg::WIC_ROUTE] & (sc_irq | ext5_src)); // [R08] [R09] [R11]
      s_next.ext_irq_four = sc_irq & ~s_reg.wic[pwr_seq_pkg::WIC_ROUTE]; // [R09]
      s_next.ext_irq_five = ext5_src & ~s_reg.wic[pwr_seq_pkg::WIC_ROUTE]; // [R09]
    end else begin
      s_next.ext_irq_zero = 1'b0; // [R11]
      s_next.ext_irq_four = 1'b0;
      s_next.ext_irq_five = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock and analog enables
    down = s_next.state == pwr_seq_pkg::ST_DOWN;
    ovr = s_next.state != pwr_seq_pkg::ST_RUN; // [R15]
    s_next.core_clock_en = ~down; // [R01]
    s_next.sc_clock_en = ~down & (ovr | ~s_next.mcc[pwr_seq_pkg::MCC_SC_DIS]); // [R13] [R15]
    s_next.usb_clock_en = ~down & (ovr | ~s_next.mcc[pwr_seq_pkg::MCC_USB_DIS]); // [R13]
    s_next.keypad_clock_en = ~down & (ovr | ~s_next.mcc[pwr_seq_pkg::MCC_KP_DIS]); // [R17]
    s_next.hs_osc_en = ~down & (ovr | ~s_next.mcc[pwr_seq_pkg::MCC_HSO_DIS]); // [R05] [R10]
    s_next.pll_en = ~down & (ovr | ~s_next.mcc[pwr_seq_pkg::MCC_HSO_DIS]); // [R05]
    s_next.vref_en = ~down; // [R05]
    s_next.bias_en = ~down; // [R05]
    s_next.osc32k_en = ~s_next.mcc[pwr_seq_pkg::MCC_OSC32K_DIS]; // [R02]
    s_next.rtc_clock_en = ~down | s_next.osc32k_en; // [R16]
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.state <= pwr_seq_pkg::ST_RUN;
      s_reg.wic <= pwr_seq_pkg::WIC_RST; // [R14]
      s_reg.mc0 <= pwr_seq_pkg::MC0_RST;
      s_reg.mcc <= pwr_seq_pkg::MCC_RST;
      s_reg.irq_status <= pwr_seq_pkg::IRQ_RST;
      s_reg.irq_mask <= pwr_seq_pkg::IRQ_RST;
      s_reg.waitrequest <= 1'b1;
      s_reg.core_clock_en <= 1'b1;
      s_reg.sc_clock_en <= 1'b1;
      s_reg.usb_clock_en <= 1'b1;
      s_reg.keypad_clock_en <= 1'b1;
      s_reg.rtc_clock_en <= 1'b1;
      s_reg.osc32k_en <= 1'b1;
      s_reg.hs_osc_en <= 1'b1;
      s_reg.pll_en <= 1'b1;
      s_reg.vref_en <= 1'b1;
      s_reg.bias_en <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign readdata = s_reg.readdata;
  assign waitrequest = s_reg.waitrequest;
  assign ext_irq_zero = s_reg.ext_irq_zero;
  assign ext_irq_four = s_reg.ext_irq_four;
  assign ext_irq_five = s_reg.ext_irq_five;
  assign irq = s_reg.irq;
  assign core_clock_en = s_reg.core_clock_en;
  assign sc_clock_en = s_reg.sc_clock_en;
  assign usb_clock_en = s_reg.usb_clock_en;
  assign keypad_clock_en = s_reg.keypad_clock_en;
  assign rtc_clock_en = s_reg.rtc_clock_en;
  assign osc32k_en = s_reg.osc32k_en;
  assign hs_osc_en = s_reg.hs_osc_en;
  assign pll_en = s_reg.pll_en;
  assign vref_en = s_reg.vref_en;
  assign bias_en = s_reg.bias_en;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  a_grace_count: assert property ( // [R03]
    $rose(s_reg.state == pwr_seq_pkg::ST_DOWN)
      |-> $past(s_reg.state) == pwr_seq_pkg::ST_GRACE && $past(s_reg.cnt) == 10'h01F)
    else $error("grace window not 32 cpu cycles");

  a_down_gating: assert property ( // [R02]
    s_reg.state == pwr_seq_pkg::ST_DOWN
      |-> !core_clock_en && !sc_clock_en && !usb_clock_en && !keypad_clock_en
        && osc32k_en == !s_reg.mcc[pwr_seq_pkg::MCC_OSC32K_DIS])
    else $error("clocks not gated in power down");

  a_analog_off: assert property ( // [R05]
    s_reg.state == pwr_seq_pkg::ST_DOWN |-> !hs_osc_en && !pll_en && !vref_en && !bias_en)
    else $error("analog still on in power down");

  a_grace_running: assert property ( // [R15]
    s_reg.state == pwr_seq_pkg::ST_GRACE
      |-> core_clock_en && hs_osc_en && pll_en && keypad_clock_en)
    else $error("clocks dropped during grace window");

  a_wake_restart: assert property ( // [R10]
    s_reg.state == pwr_seq_pkg::ST_DOWN && wake
      |=> s_reg.state == pwr_seq_pkg::ST_SETTLE && s_reg.cnt == 10'h000 ##1 vref_en && bias_en)
    else $error("wake did not restart power");

  a_settle_count: assert property ( // [R11]
    $fell(s_reg.state == pwr_seq_pkg::ST_SETTLE)
      |-> $past(s_reg.cnt) == 10'h1FF && !$past(ext_irq_zero) && ext_irq_zero)
    else $error("ext0 not released after 512 cycles");

  a_no_early_irq: assert property ( // [R11]
    s_reg.state == pwr_seq_pkg::ST_SETTLE |-> !ext_irq_zero)
    else $error("ext0 raised during settle");

  a_settle_hold: assert property ( // [R18]
    s_reg.state == pwr_seq_pkg::ST_SETTLE && !cpu_tick
      && s_next.state == pwr_seq_pkg::ST_SETTLE |=> $stable(s_reg.cnt))
    else $error("settle counter moved without tick");

  a_read_clear: assert property ( // [R12]
    accept && read && idx == pwr_seq_pkg::IDX_WAKE_IRQ_CTL
      |=> !s_reg.wic[pwr_seq_pkg::WIC_ROUTE])
    else $error("route select survived a read");

  a_keypad_gate: assert property ( // [R17]
    s_reg.state == pwr_seq_pkg::ST_RUN && s_next.state == pwr_seq_pkg::ST_RUN
      && s_next.mcc[pwr_seq_pkg::MCC_KP_DIS] |=> !keypad_clock_en)
    else $error("keypad clock not gated");

  a_route_merge: assert property ( // [R09]
    s_next.state == pwr_seq_pkg::ST_RUN && s_reg.wic[pwr_seq_pkg::WIC_ROUTE] && sc_irq
      |=> ext_irq_zero && !ext_irq_four)
    else $error("smart card irq not routed to ext0");

  c_full_cycle: cover property (
    s_reg.state == pwr_seq_pkg::ST_SETTLE ##1 s_reg.state == pwr_seq_pkg::ST_RUN);
  c_wake_route: cover property (
    s_reg.state == pwr_seq_pkg::ST_DOWN && s_reg.wic[pwr_seq_pkg::WIC_ROUTE] && ext5_src);
  c_read_clear: cover property (
    accept && read && idx == pwr_seq_pkg::IDX_WAKE_IRQ_CTL && s_reg.wic[pwr_seq_pkg::WIC_ROUTE]);

endmodule

// >>> verification/power_down_wake_sequencer_tb_top.sv
`timescale 1ns/1ps

module power_down_wake_sequencer_tb_top;
  localparam logic [15:0] WAKE = pwr_seq_pkg::IDX_WAKE_IRQ_CTL;
  localparam logic [15:0] MISC0 = pwr_seq_pkg::IDX_MISC_CTL0;
  localparam logic [15:0] MCLK = pwr_seq_pkg::IDX_MCLK_CTL;
  localparam logic [15:0] STAT = pwr_seq_pkg::IDX_IRQ_STATUS;
  localparam logic [15:0] MASK = pwr_seq_pkg::IDX_IRQ_MASK;

  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [17:0] address = 18'h00000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic [7:0] user_io_pins = 8'h00;
  logic sc_irq = 1'b0;
  logic rtc_event = 1'b0;
  logic usb_event = 1'b0;
  logic keypad_event = 1'b0;
  logic ext_irq_zero, ext_irq_four, ext_irq_five, irq;
  logic core_clock_en, sc_clock_en, usb_clock_en, keypad_clock_en, rtc_clock_en;
  logic osc32k_en, hs_osc_en, pll_en, vref_en, bias_en;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] rd;

  // short cpu divider keeps grace and settle at their bare cycle counts
  power_down_wake_sequencer #(.CPU_DIV(1)) dut_u (
    .sys_clk(sys_clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .user_io_pins(user_io_pins), .sc_irq(sc_irq),
    .rtc_event(rtc_event), .usb_event(usb_event), .keypad_event(keypad_event),
    .ext_irq_zero(ext_irq_zero), .ext_irq_four(ext_irq_four), .ext_irq_five(ext_irq_five),
    .irq(irq), .core_clock_en(core_clock_en), .sc_clock_en(sc_clock_en),
    .usb_clock_en(usb_clock_en), .keypad_clock_en(keypad_clock_en),
    .rtc_clock_en(rtc_clock_en), .osc32k_en(osc32k_en), .hs_osc_en(hs_osc_en),
    .pll_en(pll_en), .vref_en(vref_en), .bias_en(bias_en)
  );

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t signal %b expected %b", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, d};
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("[FAIL] %0t bus request never answered", $time);
    end
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk);
    if (i == 0) rtc_event <= 1'b1;
    if (i == 1) usb_event <= 1'b1;
    if (i == 2) keypad_event <= 1'b1;
    @(posedge sys_clk);
    rtc_event <= 1'b0;
    usb_event <= 1'b0;
    keypad_event <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    bus(0, WAKE, 8'h00); chk8(rd, 8'h00);
    bus(0, MISC0, 8'h00); chk8(rd, 8'h00);
    bus(0, MCLK, 8'h00); chk8(rd, 8'h0A);
    bus(0, 16'h0100, 8'h00); chk8(rd, 8'h00);
    byteenable <= 4'h0;
    bus(1, MISC0, 8'h03);
    byteenable <= 4'hF;
    bus(0, MISC0, 8'h00); chk8(rd, 8'h00);
    chk1(core_clock_en, 1'b1);
  endtask

  task automatic t_gate_clocks;
    bus(1, MCLK, 8'h4A); wait_cycles(2);
    chk1(keypad_clock_en, 1'b0);
    bus(1, MCLK, 8'h3A); wait_cycles(2);
    chk1(sc_clock_en, 1'b0);
    chk1(usb_clock_en, 1'b0);
    chk1(keypad_clock_en, 1'b1);
    bus(1, MCLK, 8'h0A); wait_cycles(2);
    chk1(usb_clock_en, 1'b1);
  endtask

  task automatic t_route_clear;
    bus(1, WAKE, 8'h80);
    bus(0, WAKE, 8'h00); chk8(rd, 8'h80);
    bus(0, WAKE, 8'h00); chk8(rd, 8'h00);
  endtask

  // rtc, usb and keypad flags each reach ext five; smart card reaches ext four
  task automatic t_wake_sources;
    logic [7:0] en;
    for (int i = 0; i < 3; i++) begin
      en = 8'h20 >> (2 * i);
      bus(1, WAKE, en);
      pulse(i); wait_cycles(2);
      chk1(ext_irq_five, 1'b1);
      bus(0, WAKE, 8'h00); chk8(rd, en | (en >> 1));
      bus(1, WAKE, en | (en >> 1)); wait_cycles(2);
      chk1(ext_irq_five, 1'b0);
    end
    // user pins reach ext0 without route select; route select then moves smart card from ext four to ext0
    user_io_pins <= 8'h10; wait_cycles(3);
    chk1(ext_irq_zero, 1'b1);
    user_io_pins <= 8'h00; wait_cycles(3);
    chk1(ext_irq_zero, 1'b0);
    sc_irq <= 1'b1; wait_cycles(3);
    chk1(ext_irq_four, 1'b1);
    chk1(ext_irq_zero, 1'b0);
    bus(1, WAKE, 8'h80); wait_cycles(2);
    chk1(ext_irq_four, 1'b0);
    chk1(ext_irq_zero, 1'b1);
    sc_irq <= 1'b0;
    bus(1, WAKE, 8'h00);
  endtask

  task automatic t_power_down;
    int n;
    bus(1, MCLK, 8'h42);
    bus(1, WAKE, 8'h82);
    bus(1, MISC0, 8'h80);
    n = 0;
    // no core here, so its halt is taken as done inside the window
    while (core_clock_en !== 1'b0 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk1(logic'(n >= 32 && n <= 34), 1'b1);
    wait_cycles(20);
    chk1(core_clock_en | sc_clock_en | usb_clock_en | keypad_clock_en, 1'b0);
    chk1(hs_osc_en | pll_en | vref_en | bias_en, 1'b0);
    chk1(osc32k_en, 1'b1);
    chk1(rtc_clock_en, 1'b1);
    @(posedge sys_clk);
    sc_irq <= 1'b1;
    n = 0;
    while (core_clock_en !== 1'b1 && n < 5) begin
      @(posedge sys_clk);
      n++;
    end
    chk1(hs_osc_en & pll_en & vref_en & bias_en, 1'b1);
    chk1(keypad_clock_en, 1'b1);
    chk1(ext_irq_zero, 1'b0);
    n = 0;
    while (ext_irq_zero !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chk1(logic'(n >= 511 && n <= 515), 1'b1);
    sc_irq <= 1'b0;
    bus(0, MISC0, 8'h00); chk8(rd, 8'h00);
    wait_cycles(2);
    chk1(keypad_clock_en, 1'b0);
    // interrupt stays quiet until unmasked, then drops on clear
    bus(0, STAT, 8'h00); chk8(rd, 8'h07);
    chk1(irq, 1'b0);
    bus(1, MASK, 8'h07); wait_cycles(2);
    chk1(irq, 1'b1);
    bus(1, STAT, 8'h07); wait_cycles(2);
    chk1(irq, 1'b0);
    bus(1, MCLK, 8'h0A);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset_values();
    t_gate_clocks();
    t_route_clear();
    t_wake_sources();
    t_power_down();
    wait_cycles(4);
    tally_and_finish();
  end

  // whole run is about 700 cycles; the 8000-cycle limit allows over ten times that
  initial begin
    #(50 * 8000);
    num_errors++;
    tally_and_finish();
  end
endmodule
